// ### src/memory_map_pkg.sv
// Purpose: Shared constants and types for the memory map decoder and SFR bank
// Assumes: 20-bit byte address, 8-bit data, 16-Kbyte ROM and 1-Kbyte RAM build
// Notes: Every address, offset, reset value and field position lives here
package memory_map_pkg;
  // Bus widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  // Whole space and region bounds
  localparam logic [19:0] SPACE_LO = 20'h00000;
  localparam logic [19:0] SPACE_HI = 20'hFFFFF;
  localparam logic [19:0] ROM_TOP = 20'h0FFFF;
  localparam logic [19:0] ROM_SIZE = 20'h04000;
  localparam logic [19:0] ROM_LO = 20'(ROM_TOP - ROM_SIZE + 20'h00001);
  localparam logic [19:0] VEC_LO = 20'h0FFDC;
  localparam logic [19:0] FLASH_LO = 20'h02400;
  localparam logic [19:0] FLASH_HI = 20'h02BFF;
  localparam logic [19:0] FLASH_BLK = 20'h00400;
  localparam logic [19:0] FLASH_B_LO = 20'(FLASH_LO + FLASH_BLK);
  localparam logic [19:0] RAM_LO = 20'h00400;
  localparam logic [19:0] RAM_SIZE = 20'h00400;
  localparam logic [19:0] RAM_HI = 20'(RAM_LO + RAM_SIZE - 20'h00001);
  localparam logic [19:0] SFR_LO = 20'h00000;
  localparam logic [19:0] SFR_HI = 20'h002FF;
  // Slice of the SFR window held by this bank
  localparam int REG_COUNT = 48;
  localparam logic [19:0] REG_SLICE_HI = 20'h0002F;
  // Register offsets
  localparam logic [5:0] OFF_PROCESSOR_MODE_0 = 6'h04;
  localparam logic [5:0] OFF_PROCESSOR_MODE_1 = 6'h05;
  localparam logic [5:0] OFF_SYS_CLK_CTRL_0 = 6'h06;
  localparam logic [5:0] OFF_SYS_CLK_CTRL_1 = 6'h07;
  localparam logic [5:0] OFF_WRITE_PROTECT = 6'h0A;
  localparam logic [5:0] OFF_OSC_STOP_DETECT = 6'h0C;
  localparam logic [5:0] OFF_WATCHDOG_RESTART = 6'h0D;
  localparam logic [5:0] OFF_WATCHDOG_START = 6'h0E;
  localparam logic [5:0] OFF_WATCHDOG_CONTROL = 6'h0F;
  localparam logic [5:0] OFF_ADDR_MATCH_CMP_0 = 6'h10;
  localparam logic [5:0] OFF_ADDR_MATCH_ENABLE = 6'h13;
  localparam logic [5:0] OFF_ADDR_MATCH_CMP_1 = 6'h14;
  localparam logic [5:0] OFF_COUNT_SOURCE_PROTECT = 6'h1C;
  localparam logic [5:0] OFF_HS_OSC_CONTROL_0 = 6'h23;
  localparam logic [5:0] OFF_HS_OSC_CONTROL_1 = 6'h24;
  localparam logic [5:0] OFF_HS_OSC_CONTROL_2 = 6'h25;
  localparam logic [5:0] OFF_PRESCALER_RESET_FLAG = 6'h28;
  localparam logic [5:0] OFF_HS_OSC_CONTROL_4 = 6'h29;
  localparam logic [5:0] OFF_HS_OSC_CONTROL_6 = 6'h2B;
  localparam logic [5:0] OFF_HS_OSC_CONTROL_7 = 6'h2C;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SYS_CLK_CTRL_0 = 8'h68;
  localparam logic [7:0] RST_SYS_CLK_CTRL_1 = 8'h20;
  localparam logic [7:0] RST_OSC_STOP_DETECT = 8'h04;
  localparam logic [7:0] RST_WATCHDOG_UNDEF = 8'h00;
  localparam logic [7:0] RST_WATCHDOG_CONTROL = 8'h1F;
  localparam logic [7:0] RST_COUNT_SOURCE_ALT = 8'h80;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Field positions
  localparam int CSP_INIT_SELECT_BIT = 7;
  localparam int PROTECT_CLOCK_BIT = 0;
  localparam int PROTECT_MODE_BIT = 1;
  // Write protection groups
  localparam logic [1:0] GRP_FREE = 2'h0;
  localparam logic [1:0] GRP_CLOCK = 2'h1;
  localparam logic [1:0] GRP_MODE = 2'h2;

  // Region selects, one hot (vector implies rom too)
  typedef struct packed {
    logic sfr;
    logic ram;
    logic flash_a;
    logic flash_b;
    logic rom;
    logic vector;
    logic reserved;
  } region_t;

  // Factory trim bytes for the high-speed oscillator
  typedef struct packed {
    logic [7:0] hs_osc_1;
    logic [7:0] hs_osc_4;
    logic [7:0] hs_osc_6;
    logic [7:0] hs_osc_7;
  } trim_t;

  // One bus request
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // Start-up sequence, Gray coded
  typedef enum logic [1:0] {
    ST_STRAP = 2'h0,
    ST_LOAD = 2'h1,
    ST_RUN = 2'h3
  } boot_state_t;
endpackage

// ### src/memory_map_sfr_decoder.sv
// Purpose: Address decoder for the 1-Mbyte space and the first SFR slice
// Assumes: One clock, async active-high reset, trim and option byte stable at reset
// Notes: Reads answer one cycle after the read strobe; bus is ignored until ready
`timescale 1ns/1ps

module memory_map_sfr_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] option_function_select,
  input wire memory_map_pkg::trim_t trim,
  output memory_map_pkg::region_t region,
  output logic [7:0] rd_data_q,
  output logic sfr_ready,
  output logic watchdog_restart_pulse_q,
  output logic watchdog_start_pulse_q,
  output logic [7:0] processor_mode_0,
  output logic [7:0] processor_mode_1,
  output logic [7:0] system_clock_control_0,
  output logic [7:0] system_clock_control_1,
  output logic [7:0] watchdog_control,
  output logic [7:0] count_source_protect,
  output logic [23:0] addr_match_compare_0,
  output logic [23:0] addr_match_compare_1,
  output logic [7:0] addr_match_enable
);

  // Bundled request, keeps the decode readable
  memory_map_pkg::bus_req_t req;
  // Start-up state
  memory_map_pkg::boot_state_t state_q;
  memory_map_pkg::boot_state_t state_d;
  // Option byte caught after reset release
  logic [7:0] option_q;
  // Register byte storage, one entry per slice offset
  // Holes are tied off below, so each entry has one driver
  logic [7:0] regs_q [memory_map_pkg::REG_COUNT];
  // Address falls inside the register slice
  // Only the low 30h bytes of the window hold registers here
  logic in_slice;
  // Offset within the slice
  logic [5:0] index;
  // Request is accepted at all
  logic bus_open;
  // Write allowed per entry after protection
  logic [memory_map_pkg::REG_COUNT-1:0] wr_hit;
  // Count-source alternative chosen by the option byte
  logic csp_alt;

  // Offset has a real register behind it
  function automatic logic reg_implemented(input logic [5:0] idx);
    case (idx)
      memory_map_pkg::OFF_PROCESSOR_MODE_0,
      memory_map_pkg::OFF_PROCESSOR_MODE_1,
      memory_map_pkg::OFF_SYS_CLK_CTRL_0,
      memory_map_pkg::OFF_SYS_CLK_CTRL_1,
      memory_map_pkg::OFF_WRITE_PROTECT,
      memory_map_pkg::OFF_OSC_STOP_DETECT,
      memory_map_pkg::OFF_WATCHDOG_RESTART,
      memory_map_pkg::OFF_WATCHDOG_START,
      memory_map_pkg::OFF_WATCHDOG_CONTROL,
      memory_map_pkg::OFF_ADDR_MATCH_ENABLE,
      memory_map_pkg::OFF_COUNT_SOURCE_PROTECT,
      memory_map_pkg::OFF_HS_OSC_CONTROL_0,
      memory_map_pkg::OFF_HS_OSC_CONTROL_1,
      memory_map_pkg::OFF_HS_OSC_CONTROL_2,
      memory_map_pkg::OFF_PRESCALER_RESET_FLAG,
      memory_map_pkg::OFF_HS_OSC_CONTROL_4,
      memory_map_pkg::OFF_HS_OSC_CONTROL_6,
      memory_map_pkg::OFF_HS_OSC_CONTROL_7: begin
        return 1'b1;
      end
      default: begin
        // Three-byte compare registers occupy a run of offsets
        return ((idx >= memory_map_pkg::OFF_ADDR_MATCH_CMP_0) &&
                (idx < memory_map_pkg::OFF_ADDR_MATCH_ENABLE)) ||
               ((idx >= memory_map_pkg::OFF_ADDR_MATCH_CMP_1) &&
                (idx < 6'(memory_map_pkg::OFF_ADDR_MATCH_CMP_1 + 6'h03)));
      end
    endcase
  endfunction

  // Constant loaded by the asynchronous reset
  // Trimmed and option-dependent bytes are fixed up later
  function automatic logic [7:0] reset_value(input logic [5:0] idx);
    case (idx)
      memory_map_pkg::OFF_SYS_CLK_CTRL_0: begin
        return memory_map_pkg::RST_SYS_CLK_CTRL_0;
      end
      memory_map_pkg::OFF_SYS_CLK_CTRL_1: begin
        return memory_map_pkg::RST_SYS_CLK_CTRL_1;
      end
      memory_map_pkg::OFF_OSC_STOP_DETECT: begin
        return memory_map_pkg::RST_OSC_STOP_DETECT;
      end
      memory_map_pkg::OFF_WATCHDOG_RESTART,
      memory_map_pkg::OFF_WATCHDOG_START: begin
        // Contents are undefined; a fixed value keeps simulation clean
        return memory_map_pkg::RST_WATCHDOG_UNDEF;
      end
      memory_map_pkg::OFF_WATCHDOG_CONTROL: begin
        return memory_map_pkg::RST_WATCHDOG_CONTROL;
      end
      default: begin
        // Mode, protect, match, count source, oscillator 0/2, prescaler flag
        return memory_map_pkg::RST_ZERO;
      end
    endcase
  endfunction

  // Which protect bit guards an offset
  // Protect register is never guarded, or it could lock itself
  function automatic logic [1:0] protect_group(input logic [5:0] idx);
    case (idx)
      memory_map_pkg::OFF_SYS_CLK_CTRL_0,
      memory_map_pkg::OFF_SYS_CLK_CTRL_1,
      memory_map_pkg::OFF_OSC_STOP_DETECT,
      memory_map_pkg::OFF_HS_OSC_CONTROL_0,
      memory_map_pkg::OFF_HS_OSC_CONTROL_1,
      memory_map_pkg::OFF_HS_OSC_CONTROL_2,
      memory_map_pkg::OFF_HS_OSC_CONTROL_4,
      memory_map_pkg::OFF_HS_OSC_CONTROL_6,
      memory_map_pkg::OFF_HS_OSC_CONTROL_7: begin
        return memory_map_pkg::GRP_CLOCK;
      end
      memory_map_pkg::OFF_PROCESSOR_MODE_0,
      memory_map_pkg::OFF_PROCESSOR_MODE_1: begin
        return memory_map_pkg::GRP_MODE;
      end
      default: begin
        return memory_map_pkg::GRP_FREE;
      end
    endcase
  endfunction

  // Trim byte for a shipped-value offset, zero otherwise
  function automatic logic [7:0] trim_byte(input logic [5:0] idx,
                                           input memory_map_pkg::trim_t t);
    case (idx)
      memory_map_pkg::OFF_HS_OSC_CONTROL_1: begin
        return t.hs_osc_1;
      end
      memory_map_pkg::OFF_HS_OSC_CONTROL_4: begin
        return t.hs_osc_4;
      end
      memory_map_pkg::OFF_HS_OSC_CONTROL_6: begin
        return t.hs_osc_6;
      end
      memory_map_pkg::OFF_HS_OSC_CONTROL_7: begin
        return t.hs_osc_7;
      end
      default: begin
        return memory_map_pkg::RST_ZERO;
      end
    endcase
  endfunction

  // Offset is filled from factory trim during start-up
  // Software may still overwrite these once the bus opens
  function automatic logic is_trimmed(input logic [5:0] idx);
    return (idx == memory_map_pkg::OFF_HS_OSC_CONTROL_1) ||
           (idx == memory_map_pkg::OFF_HS_OSC_CONTROL_4) ||
           (idx == memory_map_pkg::OFF_HS_OSC_CONTROL_6) ||
           (idx == memory_map_pkg::OFF_HS_OSC_CONTROL_7);
  endfunction

  // Gather the bus pins into one request
  always_comb begin
    req.addr = addr;
    req.wdata = wdata;
    req.wr = wr_stb;
    req.rd = rd_stb;
  end

  // Region decode, purely combinational from the address
  always_comb begin
    region = '0;
    // Windows never overlap, so the order of tests is free
    // One hot bit, vector riding with rom, keeps users simple
    // All 20 bits take part, so the space wraps nowhere
    if (req.addr <= memory_map_pkg::SFR_HI) begin
      region.sfr = 1'b1;
    end else if ((req.addr >= memory_map_pkg::RAM_LO) &&
                 (req.addr <= memory_map_pkg::RAM_HI)) begin
      region.ram = 1'b1;
    end else if ((req.addr >= memory_map_pkg::FLASH_LO) &&
                 (req.addr < memory_map_pkg::FLASH_B_LO)) begin
      region.flash_a = 1'b1;
    end else if ((req.addr >= memory_map_pkg::FLASH_B_LO) &&
                 (req.addr <= memory_map_pkg::FLASH_HI)) begin
      region.flash_b = 1'b1;
    end else if ((req.addr >= memory_map_pkg::ROM_LO) &&
                 (req.addr <= memory_map_pkg::ROM_TOP)) begin
      // ROM grows down from the top of the first 64 Kbytes
      region.rom = 1'b1;
      // Vector table is the top slice of the ROM
      region.vector = (req.addr >= memory_map_pkg::VEC_LO);
    end else begin
      // Everything else up to the top of the space is reserved
      region.reserved = 1'b1;
    end
  end

  // Slice membership and offset
  always_comb begin
    in_slice = (req.addr <= memory_map_pkg::REG_SLICE_HI);
    index = req.addr[5:0];
    bus_open = (state_q == memory_map_pkg::ST_RUN);
    // Option bit low selects the alternative count-source reset
    csp_alt = ~option_q[memory_map_pkg::CSP_INIT_SELECT_BIT];
  end

  // Start-up sequencer: catch straps, load trim, then open the bus
  // Two flops keep the bus shut for the first two edges
  // Gray order flips one bit per step on the normal path
  always_comb begin
    case (state_q)
      memory_map_pkg::ST_STRAP: begin
        state_d = memory_map_pkg::ST_LOAD;
      end
      memory_map_pkg::ST_LOAD: begin
        state_d = memory_map_pkg::ST_RUN;
      end
      memory_map_pkg::ST_RUN: begin
        state_d = memory_map_pkg::ST_RUN;
      end
      default: begin
        // Unused code falls back to a fresh start
        state_d = memory_map_pkg::ST_STRAP;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= memory_map_pkg::ST_STRAP;
    end else begin
      state_q <= state_d;
    end
  end

  // Option byte is sampled by the clock after release, never by the reset
  // Sampling in reset would make the reset value non-constant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      option_q <= memory_map_pkg::RST_ZERO;
    end else if (state_q == memory_map_pkg::ST_STRAP) begin
      option_q <= option_function_select;
    end
  end

  // Per-entry write permission, filtered by protection and implementation
  // Protect bits gate writes only; guarded reads stay open
  // A protect change applies from the next write onward
  always_comb begin
    for (int i = 0; i < memory_map_pkg::REG_COUNT; i++) begin
      wr_hit[i] = 1'b0;
      if (bus_open && req.wr && in_slice && (index == 6'(i)) &&
          reg_implemented(6'(i))) begin
        case (protect_group(6'(i)))
          memory_map_pkg::GRP_CLOCK: begin
            wr_hit[i] = regs_q[memory_map_pkg::OFF_WRITE_PROTECT]
                        [memory_map_pkg::PROTECT_CLOCK_BIT];
          end
          memory_map_pkg::GRP_MODE: begin
            wr_hit[i] = regs_q[memory_map_pkg::OFF_WRITE_PROTECT]
                        [memory_map_pkg::PROTECT_MODE_BIT];
          end
          default: begin
            wr_hit[i] = 1'b1;
          end
        endcase
      end
    end
  end

  // Register storage, one flop byte per implemented offset
  // Start-up loads beat bus writes, refused until ready anyway
  for (genvar g = 0; g < memory_map_pkg::REG_COUNT; g++) begin : g_reg
    if (reg_implemented(6'(g))) begin : g_impl
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          regs_q[g] <= reset_value(6'(g));
        end else if (state_q == memory_map_pkg::ST_LOAD) begin
          // Trim lands before the bus opens, so no read sees a stale byte
          if (is_trimmed(6'(g))) begin
            regs_q[g] <= trim_byte(6'(g), trim);
          end else if ((6'(g) == memory_map_pkg::OFF_COUNT_SOURCE_PROTECT) &&
                       csp_alt) begin
            regs_q[g] <= memory_map_pkg::RST_COUNT_SOURCE_ALT;
          end
        end else if (wr_hit[g]) begin
          regs_q[g] <= req.wdata;
        end
      end
    end else begin : g_hole
      // Empty offsets hold nothing; writes there go nowhere
      assign regs_q[g] = memory_map_pkg::UNMAPPED_READ;
    end
  end

  // Read data, one cycle after the strobe; reads never alter state
  // Data holds until the next accepted read
  // Memories answer elsewhere, so this port shows zero there
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= memory_map_pkg::RST_ZERO;
    end else if (req.rd && bus_open) begin
      if (in_slice && reg_implemented(index)) begin
        rd_data_q <= regs_q[index];
      end else begin
        // Outside this slice and at its empty offsets the port reads zero
        rd_data_q <= memory_map_pkg::UNMAPPED_READ;
      end
    end
  end

  // Watchdog writes are events as well as stored bytes
  // A write dropped while the bus is shut raises no pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdog_restart_pulse_q <= 1'b0;
      watchdog_start_pulse_q <= 1'b0;
    end else begin
      watchdog_restart_pulse_q <= wr_hit[memory_map_pkg::OFF_WATCHDOG_RESTART];
      watchdog_start_pulse_q <= wr_hit[memory_map_pkg::OFF_WATCHDOG_START];
    end
  end

  // Register contents offered to the rest of the chip
  // Straight from the flops, so users see no decode glitches
  always_comb begin
    sfr_ready = bus_open;
    processor_mode_0 = regs_q[memory_map_pkg::OFF_PROCESSOR_MODE_0];
    processor_mode_1 = regs_q[memory_map_pkg::OFF_PROCESSOR_MODE_1];
    system_clock_control_0 = regs_q[memory_map_pkg::OFF_SYS_CLK_CTRL_0];
    system_clock_control_1 = regs_q[memory_map_pkg::OFF_SYS_CLK_CTRL_1];
    watchdog_control = regs_q[memory_map_pkg::OFF_WATCHDOG_CONTROL];
    count_source_protect = regs_q[memory_map_pkg::OFF_COUNT_SOURCE_PROTECT];
    addr_match_enable = regs_q[memory_map_pkg::OFF_ADDR_MATCH_ENABLE];
    // Compare bytes are little-endian, lowest offset is the low byte
    addr_match_compare_0 = {regs_q[6'(memory_map_pkg::OFF_ADDR_MATCH_CMP_0 + 6'h02)],
                            regs_q[6'(memory_map_pkg::OFF_ADDR_MATCH_CMP_0 + 6'h01)],
                            regs_q[memory_map_pkg::OFF_ADDR_MATCH_CMP_0]};
    addr_match_compare_1 = {regs_q[6'(memory_map_pkg::OFF_ADDR_MATCH_CMP_1 + 6'h02)],
                            regs_q[6'(memory_map_pkg::OFF_ADDR_MATCH_CMP_1 + 6'h01)],
                            regs_q[memory_map_pkg::OFF_ADDR_MATCH_CMP_1]};
  end

endmodule

// ### test/cpu_bus_model.sv
// Purpose: CPU-side bus master model for the register port
// Assumes: One clock, strobes one cycle long, read data in the next cycle
// Notes: Write data is inverted once released so stale data never matches
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic clk,
  input wire logic [7:0] rd_data_q,
  output logic [19:0] addr,
  output logic [7:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  // Idle bus from time zero
  initial begin
    addr = 20'h00000;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // Write strobe for one cycle, never beside a read strobe
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    wdata <= ~d;
  endtask
  // Read strobe, data taken in the cycle after it
  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rd_data_q;
  endtask
  // Park an address for the decoder
  task automatic put(input logic [19:0] a);
    @(posedge clk);
    addr <= a;
    @(negedge clk);
  endtask
endmodule

// ### test/memory_map_asserts.sv
// Purpose: Concurrent checks on the decoder and register bank ports
// Assumes: One clock, async active-high reset, strobes one cycle long
// Notes: Reset values are judged while the bank is not yet ready
`timescale 1ns/1ps
module memory_map_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] option_function_select,
  input wire memory_map_pkg::region_t region,
  input wire logic [7:0] rd_data_q,
  input wire logic sfr_ready,
  input wire logic watchdog_restart_pulse_q,
  input wire logic watchdog_start_pulse_q,
  input wire logic [7:0] processor_mode_0,
  input wire logic [7:0] processor_mode_1,
  input wire logic [7:0] system_clock_control_0,
  input wire logic [7:0] system_clock_control_1,
  input wire logic [7:0] watchdog_control,
  input wire logic [7:0] count_source_protect,
  input wire logic [23:0] addr_match_compare_0,
  input wire logic [23:0] addr_match_compare_1,
  input wire logic [7:0] addr_match_enable
);
  // One domain for every check
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Accepted strobes only; before ready the bus is ignored
  logic rd_ok;
  logic wr_ok;
  assign rd_ok = rd_stb && sfr_ready;
  assign wr_ok = wr_stb && sfr_ready;
  sfr_decode_a: assert property (region.sfr == (addr <= 20'h002FF))
    else $error("sfr select wrong");
  ram_decode_a: assert property (region.ram == (addr >= 20'h00400 && addr <= 20'h007FF))
    else $error("ram select wrong");
  flash_decode_a: assert property (
    region.flash_a == (addr >= 20'h02400 && addr <= 20'h027FF) &&
    region.flash_b == (addr >= 20'h02800 && addr <= 20'h02BFF)) else $error("flash select wrong");
  rom_decode_a: assert property (region.rom == (addr >= 20'h0C000 && addr <= 20'h0FFFF))
    else $error("rom select wrong");
  vector_decode_a: assert property (region.vector == (addr >= 20'h0FFDC && addr <= 20'h0FFFF))
    else $error("vector select wrong");
  space_decode_a: assert property (region.reserved ==
    !(region.sfr | region.ram | region.flash_a | region.flash_b | region.rom))
    else $error("reserved select wrong");
  // Nothing can be written before ready, so values must be reset values
  reset_values_a: assert property (!sfr_ready |-> processor_mode_0 == 8'h00 &&
    system_clock_control_0 == 8'h68 && system_clock_control_1 == 8'h20 &&
    processor_mode_1 == 8'h00 && addr_match_compare_1 == 24'h000000 &&
    watchdog_control == 8'h1F && addr_match_compare_0 == 24'h000000 && addr_match_enable == 8'h00)
    else $error("reset value wrong");
  csp_alt_a: assert property ($rose(sfr_ready) |->
    count_source_protect == (option_function_select[7] ? 8'h00 : 8'h80))
    else $error("count source reset wrong");
  unmapped_read_a: assert property (rd_ok && addr > 20'h0002F |=> rd_data_q == 8'h00)
    else $error("unmapped read not zero");
  clock_read_a: assert property (
    rd_ok && addr == 20'h00006 |=> rd_data_q == $past(system_clock_control_0))
    else $error("clock control read wrong");
  restart_pulse_a: assert property (
    1'b1 |=> watchdog_restart_pulse_q == $past(wr_ok && addr == 20'h0000D))
    else $error("restart pulse wrong");
  enable_write_a: assert property (wr_ok && addr == 20'h00013 |=>
    addr_match_enable == $past(wdata)) else $error("enable write lost");
  cmp_byte_a: assert property (wr_ok && addr == 20'h00011 |=>
    addr_match_compare_0[15:8] == $past(wdata)) else $error("compare byte write lost");
  start_pulse_a: assert property (
    1'b1 |=> watchdog_start_pulse_q == $past(wr_ok && addr == 20'h0000E))
    else $error("start pulse wrong");
  match_one_a: assert property (wr_ok && addr == 20'h00016 |=>
    addr_match_compare_1[23:16] == $past(wdata)) else $error("compare one write lost");
  // Main scenarios reached
  cover property (rd_ok && addr > 20'h0002F);
  cover property ($rose(sfr_ready) && !option_function_select[7]);
  cover property (watchdog_restart_pulse_q);
endmodule
bind memory_map_sfr_decoder memory_map_asserts chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .option_function_select(option_function_select), .region(region), .rd_data_q(rd_data_q),
  .sfr_ready(sfr_ready), .watchdog_restart_pulse_q(watchdog_restart_pulse_q),
  .watchdog_start_pulse_q(watchdog_start_pulse_q), .processor_mode_1(processor_mode_1),
  .addr_match_compare_1(addr_match_compare_1),
  .processor_mode_0(processor_mode_0), .system_clock_control_0(system_clock_control_0),
  .system_clock_control_1(system_clock_control_1), .watchdog_control(watchdog_control),
  .count_source_protect(count_source_protect), .addr_match_compare_0(addr_match_compare_0),
  .addr_match_enable(addr_match_enable)
);

// ### test/tb_top.sv
// Purpose: Self-checking bench for the decoder and register bank
// Assumes: 50 MHz clock, async active-high reset, fixed seed
// Notes: A shadow of the register slice holds every expected read inside the slice
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic rst;
  logic [19:0] addr;
  logic [7:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] option_function_select;
  memory_map_pkg::trim_t trim;
  memory_map_pkg::region_t region;
  logic [7:0] rd_data_q;
  logic sfr_ready;
  logic [7:0] sh [64]; // Shadow of the slice
  logic [63:0] impl_mask = 64'h00001B38107FF4F0; // Implemented offsets
  int bad_count = 0;
  int checked = 0;
  cpu_bus_model cpu (.clk(clk), .rd_data_q(rd_data_q), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb));
  memory_map_sfr_decoder dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .option_function_select(option_function_select),
    .trim(trim), .region(region), .rd_data_q(rd_data_q), .sfr_ready(sfr_ready),
    .watchdog_restart_pulse_q(), .watchdog_start_pulse_q(), .processor_mode_0(),
    .processor_mode_1(), .system_clock_control_0(), .system_clock_control_1(),
    .watchdog_control(), .count_source_protect(), .addr_match_compare_0(),
    .addr_match_compare_1(), .addr_match_enable());
  // 20 ns clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare and count
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("Checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Expected region selects for one address
  function automatic memory_map_pkg::region_t exp_region(input logic [19:0] a);
    memory_map_pkg::region_t r;
    r.sfr = a <= 20'h002FF;
    r.ram = a >= 20'h00400 && a <= 20'h007FF;
    r.flash_a = a >= 20'h02400 && a <= 20'h027FF;
    r.flash_b = a >= 20'h02800 && a <= 20'h02BFF;
    r.rom = a >= 20'h0C000 && a <= 20'h0FFFF;
    r.vector = a >= 20'h0FFDC && a <= 20'h0FFFF;
    r.reserved = !(r.sfr | r.ram | r.flash_a | r.flash_b | r.rom);
    return r;
  endfunction
  // Reset 16 cycles, then load the shadow with reset values
  task automatic do_reset(input logic [7:0] o);
    @(posedge clk);
    option_function_select <= o;
    trim <= memory_map_pkg::trim_t'($urandom);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8 && sfr_ready !== 1'b1; i++) @(negedge clk);
    cmp("ready", 1, sfr_ready);
    for (int i = 0; i < 64; i++) sh[i] = 8'h00;
    sh[6'h06] = 8'h68;
    sh[6'h07] = 8'h20;
    sh[6'h0C] = 8'h04;
    sh[6'h0F] = 8'h1F;
    sh[6'h1C] = o[7] ? 8'h00 : 8'h80;
    {sh[6'h24], sh[6'h29], sh[6'h2B], sh[6'h2C]} = trim;
  endtask
  // Read back the whole slice
  task automatic check_all();
    logic [7:0] d;
    for (int i = 0; i < 48; i++) begin
      cpu.rd(20'(i), d);
      cmp($sformatf("reg %h", i), sh[i], d);
    end
  endtask
  // Main sequence
  initial begin
    static logic [19:0] bnd [20] = '{20'h00000, 20'h002FF, 20'h00300, 20'h003FF, 20'h00400,
      20'h007FF, 20'h00800, 20'h023FF, 20'h02400, 20'h027FF, 20'h02800, 20'h02BFF,
      20'h02C00, 20'h0BFFF, 20'h0C000, 20'h0FFDB, 20'h0FFDC, 20'h0FFFF, 20'h10000, 20'hFFFFF};
    logic [7:0] d;
    logic [5:0] o;
    rst = 1'b1;
    option_function_select = 8'h00;
    trim = '0;
    d = 8'($urandom(96199));
    do_reset(8'h7F);
    check_all();
    foreach (bnd[i]) begin
      cpu.put(bnd[i]);
      cmp("region", exp_region(bnd[i]), region);
    end
    repeat (100) begin
      cpu.put(20'($urandom));
      cmp("region", exp_region(addr), region);
    end
    // Protected and unmapped writes are dropped
    cpu.wr(20'h00006, 8'hA5);
    cpu.wr(20'h00004, 8'h3C);
    foreach (bnd[i]) cpu.wr(bnd[i] | 20'h00030, 8'h5A);
    foreach (bnd[i]) begin
      cpu.rd(bnd[i] | 20'h00030, d);
      cmp("unmapped read", 8'h00, d);
    end
    check_all();
    // Open protection, then random traffic over the slice
    cpu.wr(20'h0000A, 8'h03);
    sh[6'h0A] = 8'h03;
    repeat (80) begin
      o = 6'($urandom_range(47));
      d = 8'($urandom);
      if (o == 6'h0A) o = 6'h11;
      cpu.wr(20'(o), d);
      if (impl_mask[o]) sh[o] = d;
    end
    cpu.wr(20'h0000D, 8'hC3);
    sh[6'h0D] = 8'hC3;
    cpu.wr(20'h0000E, 8'h3C);
    sh[6'h0E] = 8'h3C;
    cpu.wr(20'h00016, 8'h96);
    sh[6'h16] = 8'h96;
    check_all();
    // Mid-run reset with the other option setting
    do_reset(8'h80);
    check_all();
    end_sim();
  end
  // Cut a hang short
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule
